// ===== src/ctw_pkg.sv
// package: register map, field positions and types for the can status and wake block
`default_nettype none
package ctw_pkg;
	localparam int NUM_FIFO = 32;
	localparam logic [7:0] OFF_OVF_SUMMARY = 8'h00;
	localparam logic [7:0] OFF_VECTOR = 8'h04;
	localparam logic [7:0] OFF_TIMER = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0C;
	localparam logic [7:0] OFF_CONFIG = 8'h10;
	localparam logic [7:0] OFF_INTERRUPT = 8'h14;
	localparam logic [7:0] OFF_FIFO_OVF_FLAG = 8'h18;
	localparam logic [7:0] OFF_FIFO_OVF_IE = 8'h1C;
	localparam logic [7:0] OFF_PENDING = 8'h20;
	localparam logic [7:0] OFF_LAST_STAMP = 8'h24;
	localparam int FIFO_OVF_IE_BIT = 19;
	localparam int FIFO_OVF_FLAG_BIT = 3;
	localparam int INT_RX_OVF_BIT = 11;
	localparam int INT_WAKE_FLAG_BIT = 14;
	localparam int INT_WAKE_IE_BIT = 30;
	localparam int CON_STOP_IN_IDLE_BIT = 13;
	localparam int CON_CAPTURE_EN_BIT = 20;
	localparam int CFG_FILTER_EN_BIT = 22;
	localparam int VEC_CODE_LSB = 0;
	localparam int VEC_FILTER_LSB = 8;
	localparam int TMR_PRESCALE_LSB = 0;
	localparam int TMR_COUNT_LSB = 16;
	localparam logic [6:0] CODE_NONE = 7'h40;
	localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
	localparam int FILTER_TIME_NS = 200;
	localparam int CLK_PERIOD_NS = 10;
	localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic TX_RECESSIVE = 1'b1;
	typedef struct packed {
		logic valid;
		logic [4:0] filter;
	} ctw_rx_event_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ctw_wb_req_t;
endpackage : ctw_pkg
`default_nettype wire

// ===== src/ctw_wake_filter.sv
// rx pin synchroniser, optional glitch filter and activity detector
`default_nettype none
module ctw_wake_filter
	import ctw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rx_pin,
	input wire logic filter_en,
	output logic rx_level,
	output logic activity
);
	logic s1_q, s2_q, s3_q;
	logic stable_q;
	logic [7:0] cnt_q;
	logic prev_q;
	wire agree = (s2_q == s3_q);
	wire differ = agree && (s3_q != stable_q);
	wire cnt_done = (cnt_q >= 8'(FILTER_CYCLES - 1));
	// with the filter on a change must last the whole filter time before it counts
	wire take = differ && (!filter_en || cnt_done);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= rx_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stable_q <= 1'b1;
			cnt_q <= 8'h00;
			prev_q <= 1'b1;
		end else begin
			prev_q <= stable_q;
			if (take) begin
				stable_q <= s3_q;
				cnt_q <= 8'h00;
			end else if (differ) begin
				cnt_q <= cnt_q + 8'h01;
			end else begin
				cnt_q <= 8'h00;
			end
		end
	end
	assign rx_level = stable_q;
	// a falling edge to dominant is bus activity
	assign activity = prev_q && !stable_q;
endmodule : ctw_wake_filter
`default_nettype wire

// ===== src/ctw_top.sv
// top: overflow summary, interrupt vector, timestamp timer and sleep/wake logic
`default_nettype none
module ctw_top
	import ctw_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [NUM_FIFO-1:0] FIFO_OVERFLOW,
	input wire logic [NUM_FIFO-1:0] FIFO_EVENT,
	input wire logic FRAME_VALID,
	input wire logic [4:0] FRAME_FILTER,
	input wire logic ENGINE_TX,
	input wire logic DISABLE_MODE,
	input wire logic DEVICE_SLEEP,
	input wire logic DEVICE_IDLE,
	input wire logic CAN_RX_PIN,
	output logic CAN_TX_PIN,
	output logic MODULE_SLEEPING,
	output logic WAKE_IRQ,
	output logic RX_OVF_IRQ,
	output logic STAMP_VALID,
	output logic [15:0] MESSAGE_TIMESTAMP_FIELD
);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge
	function automatic logic [6:0] top_code(input logic [NUM_FIFO-1:0] pend);
		logic [6:0] c;
		c = CODE_NONE;
		for (int i = 0; i < NUM_FIFO; i++) begin
			if (pend[i]) begin
				c = 7'(i);
			end
		end
		return c;
	endfunction : top_code
	////////////////////////////////////////////////////////////////////////////////
	ctw_wb_req_t req;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] control_q, config_q, timer_q, ovf_ie_q, ovf_flag_q, summary_q;
	logic [31:0] pend_q;
	logic wake_ie_q, wake_flag_q;
	logic [4:0] filter_q;
	logic [15:0] presc_cnt_q;
	logic [15:0] stamp_q;
	logic stamp_valid_q;
	logic rx_level, activity;
	assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
		sel: WB_SEL_I, dat: WB_DAT_I};
	wire access = req.cyc && req.stb && !ack_q;
	wire wr = access && req.we;
	wire wr_control = wr && (req.adr == OFF_CONTROL);
	wire wr_config = wr && (req.adr == OFF_CONFIG);
	wire wr_timer = wr && (req.adr == OFF_TIMER);
	wire wr_interrupt = wr && (req.adr == OFF_INTERRUPT);
	wire wr_ovf_flag = wr && (req.adr == OFF_FIFO_OVF_FLAG);
	wire wr_ovf_ie = wr && (req.adr == OFF_FIFO_OVF_IE);
	wire wr_pending = wr && (req.adr == OFF_PENDING);
	////////////////////////////////////////////////////////////////////////////////
	// sleep decode and pin protection
	wire stop_in_idle = control_q[CON_STOP_IN_IDLE_BIT];
	wire sleeping = DEVICE_SLEEP || (DEVICE_IDLE && stop_in_idle);
	// the filter also runs in disable so a noisy bus cannot wake a parked module
	wire filter_on = config_q[CFG_FILTER_EN_BIT] && (sleeping || DISABLE_MODE);
	ctw_wake_filter u_filter (
		.clk(CLOCK),
		.rst_n(RST_N),
		.rx_pin(CAN_RX_PIN),
		.filter_en(filter_on),
		.rx_level(rx_level),
		.activity(activity)
	);
	// engine tx is ignored while asleep, even if software broke the sleep rule
	wire tx_d = sleeping ? TX_RECESSIVE : ENGINE_TX;
	logic tx_q;
	////////////////////////////////////////////////////////////////////////////////
	// overflow flags and summary
	wire [31:0] clr_ovf_mask = wr_ovf_flag ? (req.dat & {32{req.sel[0]}}) : 32'h0000_0000;
	wire [31:0] ovf_flag_d = FIFO_OVERFLOW | (ovf_flag_q & ~clr_ovf_mask);
	wire [31:0] summary_d = (summary_q | (FIFO_OVERFLOW & ovf_ie_q)) & ovf_flag_d;
	wire rx_ovf_flag = |summary_q;
	// fifo event pending bits; set beats a same-cycle clear
	wire [31:0] pend_clr = wr_pending ? req.dat : 32'h0000_0000;
	wire [31:0] pend_d = FIFO_EVENT | (pend_q & ~pend_clr);
	wire [6:0] code = top_code(pend_q);
	////////////////////////////////////////////////////////////////////////////////
	// timestamp timer
	wire [15:0] prescale = timer_q[TMR_PRESCALE_LSB +: 16];
	wire [15:0] ts_count = timer_q[TMR_COUNT_LSB +: 16];
	wire tick = (presc_cnt_q >= prescale);
	// self-received frames arrive on the same valid strobe, so every frame is stamped unless the module is sleeping
	wire capture = FRAME_VALID && !sleeping;
	wire wake_set = sleeping && activity && wake_ie_q;
	wire wake_clr = wr_interrupt && req.sel[1] && !req.dat[INT_WAKE_FLAG_BIT];
	////////////////////////////////////////////////////////////////////////////////
	wire [31:0] vector_word = {19'h0, filter_q, 1'b0, code};
	wire [31:0] interrupt_word = {1'b0, wake_ie_q, 15'h0, wake_flag_q, 2'h0,
		rx_ovf_flag, 11'h0};
	wire [31:0] rd_mux =
		(req.adr == OFF_OVF_SUMMARY) ? summary_q :
		(req.adr == OFF_VECTOR) ? vector_word :
		(req.adr == OFF_TIMER) ? timer_q :
		(req.adr == OFF_CONTROL) ? control_q :
		(req.adr == OFF_CONFIG) ? config_q :
		(req.adr == OFF_INTERRUPT) ? interrupt_word :
		(req.adr == OFF_FIFO_OVF_FLAG) ? (ovf_flag_q << FIFO_OVF_FLAG_BIT) & 32'h0000_0008 :
		(req.adr == OFF_FIFO_OVF_IE) ? ovf_ie_q :
		(req.adr == OFF_PENDING) ? pend_q :
		(req.adr == OFF_LAST_STAMP) ? {16'h0, stamp_q} : 32'h0000_0000;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= access;
			if (access && !req.we) begin
				rdata_q <= rd_mux;
			end
		end
	end
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			control_q <= 32'h0000_0000;
			config_q <= 32'h0000_0000;
			ovf_ie_q <= 32'h0000_0000;
			wake_ie_q <= 1'b0;
		end else begin
			if (wr_control) control_q <= merge(control_q, req.dat, req.sel);
			if (wr_config) config_q <= merge(config_q, req.dat, req.sel);
			if (wr_ovf_ie) ovf_ie_q <= merge(ovf_ie_q, req.dat, req.sel);
			if (wr_interrupt && req.sel[3]) wake_ie_q <= req.dat[INT_WAKE_IE_BIT];
		end
	end
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ovf_flag_q <= 32'h0000_0000;
			summary_q <= 32'h0000_0000;
			pend_q <= 32'h0000_0000;
			wake_flag_q <= 1'b0;
			filter_q <= 5'h00;
		end else begin
			ovf_flag_q <= ovf_flag_d;
			summary_q <= summary_d;
			pend_q <= pend_d;
			wake_flag_q <= wake_set || (wake_flag_q && !wake_clr);
			if (capture) filter_q <= FRAME_FILTER;
		end
	end
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			timer_q <= TIMER_RESET;
			presc_cnt_q <= 16'h0000;
		end else if (wr_timer) begin
			timer_q <= merge(timer_q, req.dat, req.sel);
			presc_cnt_q <= 16'h0000;
		end else if (!sleeping) begin
			// timer halts while asleep since the module is powered down
			presc_cnt_q <= tick ? 16'h0000 : presc_cnt_q + 16'h0001;
			if (tick) timer_q[TMR_COUNT_LSB +: 16] <= ts_count + 16'h0001;
		end
	end
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			stamp_q <= 16'h0000;
			stamp_valid_q <= 1'b0;
			tx_q <= TX_RECESSIVE;
		end else begin
			stamp_valid_q <= capture && control_q[CON_CAPTURE_EN_BIT];
			if (capture) stamp_q <= ts_count;
			tx_q <= tx_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdata_q;
	assign CAN_TX_PIN = tx_q;
	assign MODULE_SLEEPING = sleeping;
	assign WAKE_IRQ = wake_flag_q;
	assign RX_OVF_IRQ = rx_ovf_flag;
	assign STAMP_VALID = stamp_valid_q;
	assign MESSAGE_TIMESTAMP_FIELD = stamp_q;
endmodule : ctw_top
`default_nettype wire

// ===== test/ctw_bus_node.sv
// far-side bus model: holds the rx line dominant for a requested number of clocks
`default_nettype none
module ctw_bus_node (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] len,
	output logic rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q = 8'h00;
	always @(posedge clk) cnt_q <= go ? len : cnt_q - {7'h00, cnt_q != 8'h00};
	// termination pulls an idle bus recessive, so with no pulse the line reads 1
	assign rx = cnt_q == 8'h00;
endmodule : ctw_bus_node
`default_nettype wire

// ===== test/ctw_top_checker.sv
// concurrent checks on the top ports of the can status and wake block
`default_nettype none
module ctw_top_checker (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic WB_ACK_O,
	input wire logic [31:0] FIFO_OVERFLOW,
	input wire logic FRAME_VALID,
	input wire logic DEVICE_SLEEP,
	input wire logic DEVICE_IDLE,
	input wire logic CAN_TX_PIN,
	input wire logic MODULE_SLEEPING,
	input wire logic WAKE_IRQ,
	input wire logic RX_OVF_IRQ,
	input wire logic STAMP_VALID
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////
	property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("no ack one cycle after request");
	property p_ovf; $rose(RX_OVF_IRQ) |-> $past(|FIFO_OVERFLOW) || $past(|FIFO_OVERFLOW, 2); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag without overflow");
	property p_ovf_clr; $fell(RX_OVF_IRQ) |-> $past(WB_CYC_I && WB_WE_I); endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag fell unasked");
	property p_tx; MODULE_SLEEPING [*2] |-> CAN_TX_PIN; endproperty
	a_tx: assert property (p_tx) else $error("tx dominant while asleep");
	property p_sleep; DEVICE_SLEEP |-> MODULE_SLEEPING; endproperty
	a_sleep: assert property (p_sleep) else $error("not sleeping in device sleep");
	property p_awake; !DEVICE_SLEEP && !DEVICE_IDLE |-> !MODULE_SLEEPING; endproperty
	a_awake: assert property (p_awake) else $error("sleeping while device runs");
	property p_wake_hold; WAKE_IRQ && !(WB_CYC_I && WB_WE_I) |=> WAKE_IRQ; endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake flag lost");
	property p_stamp; STAMP_VALID |-> $past(FRAME_VALID); endproperty
	a_stamp: assert property (p_stamp) else $error("stamp without valid frame");
	c_wake: cover property ($rose(WAKE_IRQ));
	c_ovf: cover property ($fell(RX_OVF_IRQ));
	c_stamp: cover property (STAMP_VALID);
endmodule : ctw_top_checker
bind ctw_top ctw_top_checker chk_i (.CLOCK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ACK_O, .FIFO_OVERFLOW, .FRAME_VALID, .DEVICE_SLEEP, .DEVICE_IDLE, .CAN_TX_PIN,
	.MODULE_SLEEPING, .WAKE_IRQ, .RX_OVF_IRQ, .STAMP_VALID);
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench: register reads, event pulses and sleep/wake traffic
`default_nettype none
module tb_top;
	import ctw_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK, RST_N, fv, dm, slp, idl, go, rx, ack, tx, msl, wk, ovi, sv, etx;
	logic [31:0] ovf, evt, dat;
	logic [15:0] ts;
	logic [7:0] len, r;
	logic [4:0] flt;
	logic [63:0] exq[$], e;
	ctw_wb_req_t req;
	int err_count, comparisons;
	ctw_top dut (.CLOCK, .RST_N, .WB_CYC_I(req.cyc), .WB_STB_I(req.stb), .WB_WE_I(req.we),
		.WB_ADR_I(req.adr), .WB_SEL_I(req.sel), .WB_DAT_I(req.dat), .WB_DAT_O(dat),
		.WB_ACK_O(ack), .FIFO_OVERFLOW(ovf), .FIFO_EVENT(evt), .FRAME_VALID(fv),
		.FRAME_FILTER(flt), .ENGINE_TX(etx), .DISABLE_MODE(dm), .DEVICE_SLEEP(slp),
		.DEVICE_IDLE(idl), .CAN_RX_PIN(rx), .CAN_TX_PIN(tx), .MODULE_SLEEPING(msl),
		.WAKE_IRQ(wk), .RX_OVF_IRQ(ovi), .STAMP_VALID(sv), .MESSAGE_TIMESTAMP_FIELD(ts));
	ctw_bus_node node (.clk(CLOCK), .go, .len, .rx);
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	////////////////////////////////////////////////////////////
	task automatic test_done;
		if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// a read notes its masked expectation; the monitor compares it on ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		int k;
		if (!w) exq.push_back({m, d & m});
		req <= '{1'b1, 1'b1, w, a, 4'hF, w ? d : 32'h0};
		k = 0;
		do @(posedge CLOCK); while (ack !== 1'b1 && ++k < 20);
		if (k >= 20) begin
			err_count++;
			test_done();
		end
		req <= '0;
		// one idle cycle keeps back-to-back requests legal
		@(posedge CLOCK);
	endtask : wb
	task automatic ev(input logic [31:0] o, input logic [31:0] v, input logic f);
		{ovf, evt, fv} <= {o, v, f};
		@(posedge CLOCK);
		{ovf, evt, fv} <= '0;
		@(posedge CLOCK);
	endtask : ev
	// fixed settle time covers sync, glitch filter and the longest pulse
	task automatic bus(input logic [7:0] l);
		{go, len} <= {1'b1, l};
		@(posedge CLOCK);
		go <= 1'b0;
		repeat (80) @(posedge CLOCK);
	endtask : bus
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	always @(posedge CLOCK) begin
		if (ack === 1'b1 && req.we === 1'b0 && exq.size() > 0) begin
			e = exq.pop_front();
			chk(dat & e[63:32], e[31:0]);
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		// engine drives dominant so the sleep checks can see the pin being overridden
		{RST_N, fv, dm, slp, idl, go, len, flt, ovf, evt, req, etx} = '0;
		{err_count, comparisons, r} = {32'h0, 32'h0, 8'h44};
		repeat (4) @(posedge CLOCK);
		RST_N <= 1'b1;
		@(posedge CLOCK);
		wb(0, OFF_VECTOR, {25'h0, CODE_NONE}, 32'h7F);
		wb(0, OFF_TIMER, TIMER_RESET, 32'hFFFF);
		wb(1, OFF_FIFO_OVF_IE, 32'h4, 0);
		ev(32'h24, 0, 0);
		chk(ovi, 1);
		wb(0, OFF_OVF_SUMMARY, 32'h4, '1);
		wb(1, OFF_OVF_SUMMARY, '1, 0);
		wb(0, OFF_OVF_SUMMARY, 32'h4, '1);
		wb(0, OFF_INTERRUPT, 32'h800, 32'h800);
		wb(1, OFF_FIFO_OVF_FLAG, 32'h4, 0);
		wb(0, OFF_OVF_SUMMARY, 0, '1);
		ev(0, 32'h1, 0);
		ev(0, 32'h20, 0);
		wb(0, OFF_VECTOR, 32'h5, 32'h7F);
		wb(1, OFF_PENDING, 32'h20, 0);
		wb(0, OFF_VECTOR, 32'h0, 32'h7F);
		wb(1, OFF_PENDING, 32'h1, 0);
		wb(0, OFF_VECTOR, 32'h40, 32'h7F);
		wb(1, OFF_CONTROL, 32'h10_0000, 0);
		repeat (3) begin
			r = lfsr(r);
			flt <= r[4:0];
			ev(0, 0, 1);
			wb(0, OFF_VECTOR, {19'h0, r[4:0], 8'h0}, 32'h1F00);
		end
		chk(tx, 32'h0);
		// prescale 0 ticks every clock; count FFFF wraps to 0 then reaches 1 at capture
		wb(1, OFF_TIMER, 32'hFFFF_0000, 0);
		ev(0, 0, 1);
		chk(ts, 32'h1);
		wb(0, OFF_LAST_STAMP, 32'h1, 32'hFFFF);
		wb(1, OFF_CONFIG, 32'h40_0000, 0);
		dm <= 1'b1;
		slp <= 1'b1;
		bus(8'd40);
		chk(wk, 0);
		wb(1, OFF_INTERRUPT, 32'h4000_0000, 0);
		bus(8'd5);
		chk(wk, 0);
		chk(tx, TX_RECESSIVE);
		bus(8'd40);
		chk(wk, 1);
		{slp, dm} <= 2'b00;
		wb(0, OFF_INTERRUPT, 32'h4000, 32'h4000);
		wb(1, OFF_INTERRUPT, 32'h4000_0000, 0);
		wb(0, OFF_INTERRUPT, 0, 32'h4000);
		wb(1, OFF_CONTROL, 32'h2000, 0);
		idl <= 1'b1;
		repeat (2) @(posedge CLOCK);
		chk(msl, 1);
		chk(tx, TX_RECESSIVE);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
